// ---- dv/t1rxe_counter_bank_tb.sv ----
// t1rxe_counter_bank_tb.sv: self-checking bench for the receive error counter bank
// assumes: rtl/ on the include path; one 20 MHz clock; AXI4-Lite master in this file
`timescale 1ns/1ns
`default_nettype none
`include "t1rxe_defines.svh"

module testbench;
   import t1rxe_pkg::*;

   localparam int TIMEOUT_CYCLES = 90000;  // crc saturation alone needs ~65600 cycles

   logic         i_clk;
   logic         i_rst_b;
   logic         i_ce;
   t1rxe_evt_t   evt;
   logic  [13:0] awaddr;
   logic         awvalid;
   logic         awready;
   logic  [31:0] wdata;
   logic         wvalid;
   logic         wready;
   logic   [1:0] bresp;
   logic         bvalid;
   logic         bready;
   logic  [13:0] araddr;
   logic         arvalid;
   logic         arready;
   logic  [31:0] rdata;
   logic   [1:0] rresp;
   logic         rvalid;
   logic         rready;
   logic         sef;
   int           error_cnt;
   int           tests_run;
   int           sef_cnt;
   int           cycles;

   t1rxe_counter_bank t1rxe_counter_bank_inst (
      .i_clk     (i_clk),
      .i_rst_b   (i_rst_b),
      .i_ce      (i_ce),
      .i_evt     (evt),
      .i_awaddr  (awaddr),
      .i_awvalid (awvalid),
      .o_awready (awready),
      .i_wdata   (wdata),
      .i_wstrb   (4'hF),
      .i_wvalid  (wvalid),
      .o_wready  (wready),
      .o_bresp   (bresp),
      .o_bvalid  (bvalid),
      .i_bready  (bready),
      .i_araddr  (araddr),
      .i_arvalid (arvalid),
      .o_arready (arready),
      .o_rdata   (rdata),
      .o_rresp   (rresp),
      .o_rvalid  (rvalid),
      .i_rready  (rready),
      .o_sef     (sef)
   );

   // 50 ns period clock
   always #25 i_clk = ~i_clk;

   // count declaration pulses and cut a hang short; the falling edge keeps
   // the count settled before the stimulus looks at it on the rising edge
   always @(negedge i_clk)
   begin
      cycles++;
      if (sef === 1'b1)
         sef_cnt++;
      if (cycles == TIMEOUT_CYCLES)
      begin
         error_cnt++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one read; arvalid held until taken, rready held until rvalid seen
   task automatic rd(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
      bit got;
      got = 0;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever
      begin
         @(posedge i_clk);
         if (got && rvalid === 1'b1)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
         if (!got && arready === 1'b1)
         begin
            got = 1;
            arvalid <= 1'b0;
         end
      end
      @(posedge i_clk);  // let rready fall before the next request raises it
   endtask

   // one write; address and data offered together, each released when taken
   task automatic wr(input logic [13:0] a, input logic [31:0] d, output logic [1:0] r);
      bit ga;
      bit gw;
      ga = 0;
      gw = 0;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever
      begin
         @(posedge i_clk);
         if (ga && gw && bvalid === 1'b1)
         begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
         if (!ga && awready === 1'b1)
         begin
            ga = 1;
            awvalid <= 1'b0;
         end
         if (!gw && wready === 1'b1)
         begin
            gw = 1;
            wvalid <= 1'b0;
         end
      end
      @(posedge i_clk);
   endtask

   // read and compare data and response in one call
   task automatic rchk(input string name, input logic [13:0] a, input logic [7:0] exp,
                       input logic [1:0] exp_resp);
      logic [31:0] d;
      logic  [1:0] r;
      rd(a, d, r);
      check(name, d, {24'h000000, exp});
      check({name, " resp"}, {30'h0, r}, {30'h0, exp_resp});
   endtask

   task automatic wchk(input string name, input logic [13:0] a, input logic [31:0] d,
                       input logic [1:0] exp_resp);
      logic [1:0] r;
      wr(a, d, r);
      check(name, {30'h0, r}, {30'h0, exp_resp});
   endtask

   // n framing bits, each one cycle frame strobe then an idle cycle
   task automatic frames(input int n, input logic err);
      repeat (n)
      begin
         evt <= t1rxe_evt_t'({1'b1, err, 1'b0});
         @(posedge i_clk);
         evt <= t1rxe_evt_t'(3'b000);
         @(posedge i_clk);
      end
   endtask

   // crc errors on n back-to-back cycles
   task automatic crc(input int n);
      evt <= t1rxe_evt_t'(3'b001);
      repeat (n) @(posedge i_clk);
      evt <= t1rxe_evt_t'(3'b000);
      @(posedge i_clk);
   endtask

   initial
   begin
      i_clk = 0; i_rst_b = 0; i_ce = 1; evt = '0; awaddr = '0; awvalid = 0;
      wdata = '0; wvalid = 0; bready = 0; araddr = '0; arvalid = 0; rready = 0;
      error_cnt = 0; tests_run = 0; sef_cnt = 0; cycles = 0;
      repeat (20) @(posedge i_clk);
      i_rst_b <= 1'b1;
      @(posedge i_clk);
      // reset values and an unmapped place
      rchk("sef reset", `T1RXE_ADDR_SEF, 8'h00, `T1RXE_RESP_OKAY);
      rchk("crc high reset", `T1RXE_ADDR_CRC_HIGH, 8'h00, `T1RXE_RESP_OKAY);
      rchk("crc low reset", `T1RXE_ADDR_CRC_LOW, 8'h00, `T1RXE_RESP_OKAY);
      rchk("unmapped", 14'h2420, 8'h00, `T1RXE_RESP_SLVERR);
      $display("test reset done");
      // 300 = 0x012C; more errors between the pair must not leak into the low byte
      crc(300);
      rchk("crc high", `T1RXE_ADDR_CRC_HIGH, 8'h01, `T1RXE_RESP_OKAY);
      crc(10);
      rchk("crc low snap", `T1RXE_ADDR_CRC_LOW, 8'h2C, `T1RXE_RESP_OKAY);
      rchk("crc high rest", `T1RXE_ADDR_CRC_HIGH, 8'h00, `T1RXE_RESP_OKAY);
      rchk("crc low rest", `T1RXE_ADDR_CRC_LOW, 8'h0A, `T1RXE_RESP_OKAY);
      rchk("crc high clr", `T1RXE_ADDR_CRC_HIGH, 8'h00, `T1RXE_RESP_OKAY);
      rchk("crc low clr", `T1RXE_ADDR_CRC_LOW, 8'h00, `T1RXE_RESP_OKAY);
      $display("test crc pair done");
      // superframe run: a good frame breaks the run, six in a row declare
      frames(5, 1'b1);
      frames(1, 1'b0);
      check("sef short run", sef_cnt, 0);
      frames(6, 1'b1);
      check("sef sf pulses", sef_cnt, 1);
      frames(12, 1'b1);
      rchk("sef count", `T1RXE_ADDR_SEF, 8'h03, `T1RXE_RESP_OKAY);
      rchk("sef cleared", `T1RXE_ADDR_SEF, 8'h00, `T1RXE_RESP_OKAY);
      $display("test sf done");
      // extended superframe run needs 24
      wchk("cfg esf", `T1RXE_ADDR_CONFIG, 32'h00000001, `T1RXE_RESP_OKAY);
      rchk("cfg read", `T1RXE_ADDR_CONFIG, 8'h01, `T1RXE_RESP_OKAY);
      sef_cnt = 0;
      frames(23, 1'b1);
      frames(1, 1'b0);
      check("esf short run", sef_cnt, 0);
      frames(24, 1'b1);
      check("esf pulses", sef_cnt, 1);
      rchk("esf count", `T1RXE_ADDR_SEF, 8'h01, `T1RXE_RESP_OKAY);
      wchk("cfg sf", `T1RXE_ADDR_CONFIG, 32'h00000000, `T1RXE_RESP_OKAY);
      $display("test esf done");
      // 256 declarations saturate the 8-bit count; a write must not touch it
      sef_cnt = 0;
      frames(1536, 1'b1);
      check("sef sat pulses", sef_cnt, 256);
      wchk("sef write", `T1RXE_ADDR_SEF, 32'h00000055, `T1RXE_RESP_SLVERR);
      rchk("sef sat", `T1RXE_ADDR_SEF, 8'hFF, `T1RXE_RESP_OKAY);
      rchk("sef sat clr", `T1RXE_ADDR_SEF, 8'h00, `T1RXE_RESP_OKAY);
      // 65540 errors saturate the 16-bit count
      crc(65540);
      rchk("crc sat high", `T1RXE_ADDR_CRC_HIGH, 8'hFF, `T1RXE_RESP_OKAY);
      rchk("crc sat low", `T1RXE_ADDR_CRC_LOW, 8'hFF, `T1RXE_RESP_OKAY);
      rchk("crc sat clr", `T1RXE_ADDR_CRC_HIGH, 8'h00, `T1RXE_RESP_OKAY);
      // with the clock enable low, errors must not be counted
      i_ce <= 1'b0;
      crc(5);
      i_ce <= 1'b1;
      rchk("ce low pair", `T1RXE_ADDR_CRC_LOW, 8'h00, `T1RXE_RESP_OKAY);
      rchk("ce low high", `T1RXE_ADDR_CRC_HIGH, 8'h00, `T1RXE_RESP_OKAY);
      $display("test saturation done");
      results();
   end
endmodule

`default_nettype wire

// ---- rtl/t1rxe_counter_bank.sv ----
// t1rxe_counter_bank.sv: receive error counter bank behind an AXI4-Lite slave
// assumes: framer strobes on i_clk, one cycle wide; master keeps AXI valid rules
`timescale 1ns/1ns
`default_nettype none
`include "t1rxe_defines.svh"

// Behaviour
// - keep an 8-bit count of severely errored frames since its last read
// - reading the severe frame count returns it and then zeroes it
// - SF format declares after six errored terminal framing bits in a row
// - EXTENDED_SUPERFRAME_FORMAT format declares after 24 errored pattern sequence bits in a row
// - count CRC-6 errors in 16 bits; high register shows bits 15 to 8
// - low register shows bits 7 to 0 of the CRC-6 count
// - the 16-bit CRC-6 count holds errors since the last high-byte read, which clears it
// - high read clears the 16-bit count; the low read that follows returns the held low byte
module t1rxe_counter_bank
(
   input  wire logic                 i_clk,
   input  wire logic                 i_rst_b,
   input  wire logic                 i_ce,
   input  wire t1rxe_pkg::t1rxe_evt_t i_evt,
   // AXI4-Lite write channels
   input  wire logic          [13:0] i_awaddr,
   input  wire logic                 i_awvalid,
   output logic                      o_awready,
   input  wire logic          [31:0] i_wdata,
   input  wire logic           [3:0] i_wstrb,
   input  wire logic                 i_wvalid,
   output logic                      o_wready,
   output logic               [1:0]  o_bresp,
   output logic                      o_bvalid,
   input  wire logic                 i_bready,
   // AXI4-Lite read channels
   input  wire logic          [13:0] i_araddr,
   input  wire logic                 i_arvalid,
   output logic                      o_arready,
   output logic              [31:0]  o_rdata,
   output logic               [1:0]  o_rresp,
   output logic                      o_rvalid,
   input  wire logic                 i_rready,
   // severe frame declaration, for other monitors
   output logic                      o_sef
);
   import t1rxe_pkg::*;

   // decode a read address into a counter selector
   function automatic t1rxe_sel_t dec_sel(input logic [13:0] a);
      unique case (a)
         `T1RXE_ADDR_SEF:      dec_sel = T1RXE_SEL_SEF;
         `T1RXE_ADDR_CRC_HIGH: dec_sel = T1RXE_SEL_CRC_HIGH;
         `T1RXE_ADDR_CRC_LOW:  dec_sel = T1RXE_SEL_CRC_LOW;
         default:              dec_sel = T1RXE_SEL_NONE;
      endcase
   endfunction

   logic [7:0]  cfg;
   logic        esf_mode;
   logic [7:0]  sef_count;
   logic [15:0] crc_count;
   logic [7:0]  crc_low_held;
   logic        low_held;
   logic        aw_got;
   logic        w_got;
   logic [13:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        rd_take;
   logic        wr_fire;
   logic        clr_sef;
   logic        clr_crc;
   t1rxe_sel_t  rd_sel;

   assign esf_mode = cfg[`T1RXE_CFG_ESF_BIT];

   // framing run detector feeding the severe frame counter
   t1rxe_sef_detect u_detect
   (
      .i_clk       (i_clk),
      .i_rst_b     (i_rst_b),
      .i_ce        (i_ce),
      .i_esf       (esf_mode),
      .i_frame_end (i_evt.frame_end),
      .i_frame_err (i_evt.frame_err),
      .o_sef       (o_sef)
   );

   // 8-bit severe frame count, cleared by its own read
   t1rxe_sat_counter #(.W(8)) u_sef_cnt
   (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_ce    (i_ce),
      .i_inc   (o_sef),
      .i_clr   (clr_sef),
      .o_count (sef_count)
   );

   // 16-bit CRC-6 count, cleared when the high byte is read
   t1rxe_sat_counter #(.W(16)) u_crc_cnt
   (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_ce    (i_ce),
      .i_inc   (i_evt.crc_err),
      .i_clr   (clr_crc),
      .o_count (crc_count)
   );

   // read channel: one read at a time, answered the cycle after arvalid
   assign o_arready = !o_rvalid;
   assign rd_take   = i_ce && i_arvalid && o_arready;
   assign rd_sel    = dec_sel(i_araddr);
   assign clr_sef   = rd_take && rd_sel == T1RXE_SEL_SEF;
   // the high-byte read snapshots the count and restarts it at once, so
   // nothing is lost between the two byte reads
   assign clr_crc   = rd_take && rd_sel == T1RXE_SEL_CRC_HIGH;

   // low-byte snapshot taken with the high byte, kept until the low read
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         crc_low_held <= 8'h00;
         low_held     <= 1'b0;
      end
      else if (i_ce && rd_take)
      begin
         if (rd_sel == T1RXE_SEL_CRC_HIGH)
         begin
            crc_low_held <= crc_count[7:0];
            low_held     <= 1'b1;
         end
         else if (rd_sel == T1RXE_SEL_CRC_LOW)
            low_held     <= 1'b0;           // pair finished
      end
   end

   // read data: registered with the request
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_rvalid <= 1'b0;
         o_rdata  <= 32'h0000_0000;
         o_rresp  <= `T1RXE_RESP_OKAY;
      end
      else if (i_ce)
      begin
         if (o_rvalid && i_rready)
            o_rvalid <= 1'b0;
         if (rd_take)
         begin
            o_rvalid <= 1'b1;
            o_rresp  <= `T1RXE_RESP_OKAY;
            unique case (rd_sel)
               T1RXE_SEL_SEF:
                  o_rdata <= {24'h000000, sef_count};
               T1RXE_SEL_CRC_HIGH:
                  o_rdata <= {24'h000000, crc_count[15:8]};
               T1RXE_SEL_CRC_LOW:
                  // a low read without a high read first sees the live count
                  // and leaves it running; only a high-byte read clears
                  o_rdata <= {24'h000000,
                              low_held ? crc_low_held : crc_count[7:0]};
               T1RXE_SEL_NONE:
               begin
                  if (i_araddr == `T1RXE_ADDR_CONFIG)
                     o_rdata <= {24'h000000, cfg};
                  else
                  begin
                     o_rdata <= 32'h0000_0000;
                     o_rresp <= `T1RXE_RESP_SLVERR;
                  end
               end
            endcase
         end
      end
   end

   // write channel: address and data taken in either order, then response
   assign o_awready = !aw_got && !o_bvalid;
   assign o_wready  = !w_got && !o_bvalid;
   assign wr_fire   = aw_got && w_got && !o_bvalid;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         aw_got   <= 1'b0;
         w_got    <= 1'b0;
         aw_addr  <= 14'h0000;
         w_data   <= 32'h0000_0000;
         w_strb   <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp  <= `T1RXE_RESP_OKAY;
      end
      else if (i_ce)
      begin
         if (i_awvalid && o_awready)
         begin
            aw_got  <= 1'b1;
            aw_addr <= i_awaddr;
         end
         if (i_wvalid && o_wready)
         begin
            w_got  <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end
         if (wr_fire)
         begin
            aw_got   <= 1'b0;
            w_got    <= 1'b0;
            o_bvalid <= 1'b1;
            // counters are read-only; only config accepts writes
            o_bresp  <= (aw_addr == `T1RXE_ADDR_CONFIG) ? `T1RXE_RESP_OKAY
                                                        : `T1RXE_RESP_SLVERR;
         end
         else if (o_bvalid && i_bready)
            o_bvalid <= 1'b0;
      end
   end

   // configuration register: framing format select
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         cfg <= `T1RXE_CFG_RESET;
      else if (i_ce && wr_fire && aw_addr == `T1RXE_ADDR_CONFIG && w_strb[0])
         cfg <= w_data[7:0];
   end

   chk_sef_read_clears: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (clr_sef && !o_sef) |=> sef_count == 8'h00)
      else $error("severe count not cleared by read");

   chk_sef_read_value: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      clr_sef |=> o_rvalid && o_rdata[7:0] == $past(sef_count))
      else $error("severe count read wrong");

   chk_high_byte_data: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      clr_crc |=> o_rdata == {24'h000000, $past(crc_count[15:8])})
      else $error("high byte wrong");

   chk_low_pair_match: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (rd_take && rd_sel == T1RXE_SEL_CRC_LOW && low_held)
      |=> o_rdata[7:0] == $past(crc_low_held))
      else $error("low byte not matched to high read");

   chk_crc_clear_high: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (clr_crc && !i_evt.crc_err) |=> crc_count == 16'h0000)
      else $error("crc count not cleared");

   chk_low_unpaired: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (rd_take && rd_sel == T1RXE_SEL_CRC_LOW && !low_held)
      |=> o_rdata[7:0] == $past(crc_count[7:0]))
      else $error("low byte wrong");

   chk_pair_done: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_ce && rd_take && rd_sel == T1RXE_SEL_CRC_LOW) |=> !low_held)
      else $error("pair not finished");

   chk_read_answer: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      rd_take |=> o_rvalid)
      else $error("read not answered");

endmodule
`default_nettype wire

// ---- rtl/t1rxe_defines.svh ----
// t1rxe_defines.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the counter bank files
`ifndef T1RXE_DEFINES_SVH
`define T1RXE_DEFINES_SVH

// register indices as printed; byte address is four times the index
`define T1RXE_IDX_SEF         12'h904
`define T1RXE_IDX_CRC_HIGH    12'h905
`define T1RXE_IDX_CRC_LOW     12'h906
`define T1RXE_IDX_CONFIG      12'h900
// byte addresses
`define T1RXE_ADDR_SEF        14'h2410
`define T1RXE_ADDR_CRC_HIGH   14'h2414
`define T1RXE_ADDR_CRC_LOW    14'h2418
`define T1RXE_ADDR_CONFIG     14'h2400
// config register fields
`define T1RXE_CFG_ESF_BIT     0
`define T1RXE_CFG_RESET       8'h00
// counter reset values
`define T1RXE_SEF_RESET       8'h00
`define T1RXE_CRC_RESET       16'h0000
// errored-frame run lengths that declare a severely errored frame
`define T1RXE_SF_RUN_FRAMES   6
`define T1RXE_ESF_RUN_FRAMES  24
// run durations in microseconds, as printed
`define T1RXE_SF_RUN_US       750
`define T1RXE_ESF_RUN_US      3000
// AXI responses
`define T1RXE_RESP_OKAY       2'h0
`define T1RXE_RESP_SLVERR     2'h2

`endif

// ---- rtl/t1rxe_pkg.sv ----
// t1rxe_pkg.sv: types shared by the receive error counter bank
// assumes: constants come from t1rxe_defines.svh
package t1rxe_pkg;

   // register selector decoded from a read address
   typedef enum logic [1:0] {
      T1RXE_SEL_NONE,
      T1RXE_SEL_SEF,
      T1RXE_SEL_CRC_HIGH,
      T1RXE_SEL_CRC_LOW
   } t1rxe_sel_t;

   // per-frame strobes from the receive framer
   typedef struct packed {
      logic frame_end;  // one pulse per received frame
      logic frame_err;  // framing bit of this frame in error, valid with frame_end
      logic crc_err;    // one CRC-6 synchronization-bit error
   } t1rxe_evt_t;

endpackage

// ---- rtl/t1rxe_sat_counter.sv ----
// t1rxe_sat_counter.sv: saturating event counter with clear
// assumes: clear and increment in one cycle leave a count of one
`timescale 1ns/1ns
`default_nettype none
`include "t1rxe_defines.svh"

module t1rxe_sat_counter
#(
   parameter int W = 8
)
(
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   input  wire logic         i_ce,
   input  wire logic         i_inc,
   input  wire logic         i_clr,
   output logic      [W-1:0] o_count
);
   import t1rxe_pkg::*;

   // a clear in the same cycle as an event keeps that event
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         o_count <= '0;
      else if (i_ce)
      begin
         if (i_clr)
            o_count <= i_inc ? W'(1) : '0;
         else if (i_inc && o_count != '1)
            o_count <= o_count + W'(1); // saturate at all ones
      end
   end

   chk_count_saturates: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_ce && !i_clr && o_count == '1) |=> o_count == '1)
      else $error("counter wrapped");

   chk_clear_keeps_evt: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_ce && i_clr) |=> o_count == ($past(i_inc) ? W'(1) : W'(0)))
      else $error("clear lost event");

endmodule
`default_nettype wire

// ---- rtl/t1rxe_sef_detect.sv ----
// t1rxe_sef_detect.sv: declares a severely errored frame from errored-frame runs
// assumes: strobes are synchronous to i_clk and one cycle wide
`timescale 1ns/1ns
`default_nettype none
`include "t1rxe_defines.svh"

module t1rxe_sef_detect
#(
   parameter int SF_RUN  = `T1RXE_SF_RUN_FRAMES,
   parameter int ESF_RUN = `T1RXE_ESF_RUN_FRAMES
)
(
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_ce,
   input  wire logic i_esf,
   input  wire logic i_frame_end,
   input  wire logic i_frame_err,
   output logic      o_sef
);
   import t1rxe_pkg::*;

   logic [4:0] run;
   logic [4:0] target;

   // SF needs 6 (0.75 ms) and EXTENDED_SUPERFRAME_FORMAT 24 (3 ms) errored frames in a row
   assign target = i_esf ? 5'(ESF_RUN) : 5'(SF_RUN);

   // run counter restarts on any good frame; one event per completed run
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         run   <= 5'h00;
         o_sef <= 1'b0;
      end
      else if (i_ce)
      begin
         o_sef <= 1'b0;
         if (i_frame_end)
         begin
            if (!i_frame_err)
               run <= 5'h00;
            else if (run + 5'h01 >= target)
            begin
               run   <= 5'h00; // next run begins fresh, so events are contiguous windows
               o_sef <= 1'b1;
            end
            else
               run <= run + 5'h01;
         end
      end
   end

   // six errored SF frames in a row raise exactly one declaration
   chk_sf_run_length: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_ce && !i_esf && i_frame_end && i_frame_err && run == 5'(SF_RUN - 1))
      |=> o_sef)
      else $error("sf run did not declare");

   chk_sef_needs_err: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      $rose(o_sef) |-> $past(i_frame_err) && $past(i_frame_end))
      else $error("declaration without errored frame");

endmodule
`default_nettype wire
